// file: kms_pkg.sv
package kms_pkg;
  // register byte offsets
  localparam logic [7:0] KMS_CTRL_OFS = 8'h00;
  localparam logic [7:0] KMS_STAT_OFS = 8'h04;
  localparam logic [7:0] KMS_MASK_OFS = 8'h08;
  localparam logic [7:0] KMS_KEY_OFS = 8'h0C;
  localparam logic [7:0] KMS_LVL_OFS = 8'h10;
  // control fields
  localparam int KMS_CTRL_EN_BIT = 0;
  localparam int KMS_CTRL_ROWS_LSB = 4;
  localparam int KMS_CTRL_COLS_LSB = 8;
  // status / mask bit positions
  localparam int KMS_ST_KEY_BIT = 0;
  localparam int KMS_ST_GHOST_BIT = 1;
  localparam int KMS_ST_OVF_BIT = 2;
  localparam int KMS_ST_W = 3;
  // reset values
  localparam logic [31:0] KMS_CTRL_RST = 32'h0000_1471;
  localparam logic [2:0] KMS_MASK_RST = 3'h0;
  // timing
  localparam int KMS_SYS_HZ = 100_000_000;
  localparam int KMS_SCAN_HZ = 128_000;
  localparam int KMS_TICK_DIV = KMS_SYS_HZ / KMS_SCAN_HZ;
  localparam int KMS_DEB_TICKS = 4;
  // control register contents
  typedef struct packed {
    logic [4:0] cols;
    logic [3:0] rows;
    logic en;
  } kms_ctrl_t;
  // the key matrix column pins
  typedef struct packed {
    logic [19:0] col;
    logic [19:0] col_oe;
  } kms_cols_t;
endpackage

// file: kms_scanner.sv
`timescale 1ns/100ps
// Functional notes
// RULE1: column count programmable from 1 to 20
// RULE2: row count programmable 1 to 8
// RULE3: sixteen byte key code buffer
// RULE4: scan steps at 128 kHz rate
// RULE5: scan clock request dropped when idle
// RULE6: n-key rollover, ghost pair locked out
// RULE7: codes held until read or overflow
// RULE8: rows debounced and glitches filtered
// RULE9: three states idle scan end, starts idle
// RULE10: idle drives all columns high
// RULE11: row change in idle starts scan
// RULE12: idle clears row-hit and key index
// RULE13: row then column counting, then scan end
// RULE14: key index advances per scanned position
// RULE15: row-hit ORs rows when two hits
// RULE16: hit on a row already hit in an earlier multi-hit column sets ghost flag
// RULE17: scan end rescans on keys, else idle
// RULE18: host may poll key status register
// RULE19: full buffer drops code, sets overflow
module kms_scanner
  import kms_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int MAX_ROWS = 8,
  parameter int MAX_COLS = 20
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] row_in,
  output kms_pkg::kms_cols_t cols_out,
  output logic clk_req,
  output logic irq
);
  import kms_pkg::*;

  initial
  begin
    if (DEPTH != 16 || MAX_ROWS != 8 || MAX_COLS != 20)
      $error("kms_scanner: only the 16 deep, 8 by 20 geometry is supported");
  end

  typedef enum logic [1:0] {KMS_IDLE, KMS_SCAN, KMS_SEND} kms_state_t;
  // half a scan step: long enough to drop spikes, short enough to settle per column
  localparam int DEB_HOLD = KMS_TICK_DIV / 2;

  kms_state_t state; // scan sequencer
  kms_ctrl_t ctrl; // software control
  logic [2:0] stat; // sticky events
  logic [2:0] mask; // interrupt enables
  logic [7:0] row_s1, row_s2; // row synchroniser
  logic [7:0] row_deb; // filtered row levels
  logic [7:0] row_cand; // candidate level under test
  logic [9:0] deb_cnt; // cycles the rows have held still
  logic [9:0] div_cnt; // tick divider
  logic tick; // one 128 kHz step
  logic [2:0] row_cnt; // current row
  logic [4:0] col_cnt; // current column
  logic [7:0] key_idx; // linear key position
  logic [7:0] row_hit; // rows with multi-hit columns
  logic [7:0] col_hits; // hits seen in this column
  logic any_key; // a key found this pass
  logic [7:0] fifo [0:15]; // key code buffer
  logic [3:0] wptr, rptr; // buffer pointers
  logic [4:0] count; // buffer fill
  logic [7:0] row_idle; // row level from the previous cycle

  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire rd_key = acc && !pwrite && paddr == KMS_KEY_OFS;
  wire last_row = row_cnt == 3'(ctrl.rows - 4'd1);
  wire last_col = col_cnt == ctrl.cols - 5'd1;
  wire hit = row_deb[row_cnt];
  // a ghost needs this row already hit in an earlier multi-key column
  wire ghost = hit && row_hit[row_cnt];
  wire push = state == KMS_SCAN && tick && hit && !ghost;
  wire full = count == 5'd16;
  wire pop = rd_key && count != 5'd0;
  // two or more hits in the column counting the current row
  wire [7:0] hits_now = col_hits | (hit ? 8'(1) << row_cnt : 8'h00);
  wire multi = (hits_now & (hits_now - 8'h01)) != 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // row synchroniser and debounce
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      row_s1 <= 8'h00;
      row_s2 <= 8'h00;
    end
    else
    begin
      row_s1 <= row_in;
      row_s2 <= row_s1;
    end
  end

  // a new column's first row is sampled one step after the move, so the filter must settle inside one step
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      row_cand <= 8'h00;
      deb_cnt <= 10'd0;
      row_deb <= 8'h00;
    end
    else if (row_s2 != row_cand)
    begin
      row_cand <= row_s2; // RULE8
      deb_cnt <= 10'd0;
    end
    else if (deb_cnt != 10'(DEB_HOLD))
      deb_cnt <= deb_cnt + 10'd1;
    else
      row_deb <= row_cand; // RULE8
  end

  ////////////////////////////////////////////////////////////////////////
  // 128 kHz step, only runs while the clock is requested
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt <= 10'd0;
      tick <= 1'b0;
    end
    else if (!clk_req)
    begin
      div_cnt <= 10'd0; // RULE5
      tick <= 1'b0;
    end
    else if (div_cnt == 10'(KMS_TICK_DIV - 1))
    begin
      div_cnt <= 10'd0;
      tick <= 1'b1; // RULE4
    end
    else
    begin
      div_cnt <= div_cnt + 10'd1;
      tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= KMS_IDLE; // RULE9
      clk_req <= 1'b0;
      row_idle <= 8'h00;
    end
    else
    begin
      // tracked in every state so a return to idle compares against a fresh view
      row_idle <= row_s2;
      case (state)
        KMS_IDLE:
        begin
          // any edge on a row wakes the scanner
          if (ctrl.en && row_s2 != row_idle)
          begin
            clk_req <= 1'b1; // RULE11
            state <= KMS_SCAN; // RULE11
          end
        end
        KMS_SCAN:
          if (tick && last_row && last_col)
            state <= KMS_SEND; // RULE13
        KMS_SEND:
          if (any_key)
            state <= KMS_SCAN; // RULE17
          else
          begin
            state <= KMS_IDLE; // RULE17
            clk_req <= 1'b0; // RULE5 RULE17
          end
        default:
          state <= KMS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // row, column and key index counters
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      row_cnt <= 3'd0;
      col_cnt <= 5'd0;
      key_idx <= 8'h00;
    end
    else if (state != KMS_SCAN)
    begin
      row_cnt <= 3'd0;
      col_cnt <= 5'd0;
      if (state == KMS_IDLE)
        key_idx <= 8'h00; // RULE12
      else
        key_idx <= 8'h00; // each pass restarts at position zero
    end
    else if (tick)
    begin
      key_idx <= key_idx + 8'h01; // RULE14
      if (last_row)
      begin
        row_cnt <= 3'd0; // RULE2 RULE13
        col_cnt <= last_col ? 5'd0 : col_cnt + 5'd1; // RULE1 RULE13
      end
      else
        row_cnt <= row_cnt + 3'd1; // RULE13
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ghost tracking
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      row_hit <= 8'h00;
      col_hits <= 8'h00;
      any_key <= 1'b0;
    end
    else if (state != KMS_SCAN)
    begin
      row_hit <= 8'h00; // RULE12
      col_hits <= 8'h00;
      any_key <= 1'b0;
    end
    else if (tick)
    begin
      if (hit)
        any_key <= 1'b1;
      if (last_row)
      begin
        col_hits <= 8'h00;
        if (multi)
          row_hit <= row_hit | row_deb; // RULE15
      end
      else
        col_hits <= hits_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // column drive: all high at idle, one column low while scanning
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cols_out.col <= '1;
      cols_out.col_oe <= '1;
    end
    else
    begin
      cols_out.col_oe <= '1;
      if (state == KMS_SCAN)
        cols_out.col <= ~(20'(1) << col_cnt);
      else
        cols_out.col <= '1; // RULE10
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // key code buffer; ghost keys never enter it
  always_ff @(posedge pclk)
  begin
    if (push && !full)
      fifo[wptr] <= key_idx; // RULE3 RULE6
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wptr <= 4'd0;
      rptr <= 4'd0;
      count <= 5'd0;
    end
    else
    begin
      if (push && !full)
        wptr <= wptr + 4'd1;
      if (pop)
        rptr <= rptr + 4'd1; // RULE7
      count <= count + 5'(push && !full) - 5'(pop); // RULE7
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers over apb; set wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= '{cols: KMS_CTRL_RST[KMS_CTRL_COLS_LSB +: 5],
                rows: KMS_CTRL_RST[KMS_CTRL_ROWS_LSB +: 4], en: KMS_CTRL_RST[KMS_CTRL_EN_BIT]};
      mask <= KMS_MASK_RST;
      stat <= 3'h0;
    end
    else
    begin
      if (wr && paddr == KMS_CTRL_OFS)
      begin
        ctrl.en <= pwdata[KMS_CTRL_EN_BIT];
        // out of range sizes are clamped so the counters always terminate
        if (pwdata[KMS_CTRL_ROWS_LSB +: 4] == 4'd0)
          ctrl.rows <= 4'd1;
        else if (pwdata[KMS_CTRL_ROWS_LSB +: 4] > 4'd8)
          ctrl.rows <= 4'd8; // RULE2
        else
          ctrl.rows <= pwdata[KMS_CTRL_ROWS_LSB +: 4];
        if (pwdata[KMS_CTRL_COLS_LSB +: 5] == 5'd0)
          ctrl.cols <= 5'd1;
        else if (pwdata[KMS_CTRL_COLS_LSB +: 5] > 5'd20)
          ctrl.cols <= 5'd20; // RULE1
        else
          ctrl.cols <= pwdata[KMS_CTRL_COLS_LSB +: 5];
      end
      if (wr && paddr == KMS_MASK_OFS)
        mask <= pwdata[2:0];
      stat <= (stat & ~((wr && paddr == KMS_STAT_OFS) ? pwdata[2:0] : 3'h0))
              | {push && full, // RULE19
                 state == KMS_SCAN && tick && ghost, // RULE16 RULE6
                 push};
    end
  end

  // read data, ready and error; unmapped addresses answer slverr
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(stat & mask);
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(paddr == KMS_CTRL_OFS || paddr == KMS_STAT_OFS
                 || paddr == KMS_MASK_OFS || paddr == KMS_KEY_OFS || paddr == KMS_LVL_OFS);
      case (paddr)
        KMS_CTRL_OFS: prdata <= {19'h0, ctrl.cols, ctrl.rows, 3'h0, ctrl.en};
        KMS_STAT_OFS: prdata <= {29'h0, stat}; // RULE18
        KMS_MASK_OFS: prdata <= {29'h0, mask};
        KMS_KEY_OFS: prdata <= {24'h0, count == 5'd0 ? 8'hFF : fifo[rptr]};
        KMS_LVL_OFS: prdata <= {27'h0, count};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// file: kms_chk.sv
`timescale 1ns/100ps
module kms_chk
  import kms_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic [7:0] row_in,
  input wire kms_pkg::kms_cols_t cols_out,
  input wire logic clk_req
);
  // one clock domain, so one clocking and one reset for all
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////////////
  ready_next_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held two cycles");
  start_idle_a: assert property ($rose(presetn) |-> &cols_out.col && !clk_req)
    else $error("not idle after reset");
  col_drive_a: assert property (&cols_out.col_oe)
    else $error("column not driven");
  one_col_a: assert property ($countones(~cols_out.col) <= 1)
    else $error("two columns low");
  // a low column means scanning, which needs the slow clock
  scan_clk_a: assert property (!(&cols_out.col) |-> clk_req || $past(clk_req))
    else $error("scan without clock request");
  wake_up_a: assert property (!clk_req && $changed(row_in) && |row_in |-> ##[1:4] clk_req)
    else $error("row change did not wake");
  // steps are slow, so a column never changes twice in a few cycles
  step_slow_a: assert property ($changed(cols_out.col) && !(&cols_out.col) |=> $stable(cols_out.col) [*8])
    else $error("column step too fast");
  cover property ($rose(clk_req));
  cover property ($fell(clk_req));
  cover property (!(&cols_out.col) && |row_in);
endmodule
bind kms_scanner kms_chk u_kms_chk (.*);

// file: kms_matrix.sv
`timescale 1ns/100ps
module kms_matrix
  import kms_pkg::*;
(
  input wire kms_pkg::kms_cols_t cols,
  input wire logic [159:0] keys,
  output logic [7:0] row_in
);
  // switch at bit col*8+row; idle (all high) shows every key
  always_comb
  begin
    for (int r = 0; r < 8; r++)
    begin
      row_in[r] = 1'b0;
      for (int c = 0; c < 20; c++)
        if (keys[c*8+r] && (&cols.col || !cols.col[c]))
          row_in[r] = 1'b1;
    end
  end
endmodule

// file: key_matrix_scanner_tb.sv
`timescale 1ns/100ps
module key_matrix_scanner_tb;
  import kms_pkg::*;
  // expected answer: error flag, bits compared, value
  typedef struct packed {logic err; logic [31:0] care; logic [31:0] val;} kms_exp_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic pready, pslverr, clk_req, irq;
  logic [7:0] paddr = 0, row_in;
  logic [31:0] pwdata = 0, prdata, rnd = 32'h0000_e550;
  logic [159:0] keys = 0;
  kms_cols_t cols_out;
  kms_exp_t q[$];
  int n_mismatch = 0, cmp_count = 0;
  int r, c;
  always #5 pclk = ~pclk;
  kms_scanner u_kms_scanner (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .row_in(row_in),
    .cols_out(cols_out), .clk_req(clk_req), .irq(irq));
  kms_matrix u_kms_matrix (.cols(cols_out), .keys(keys), .row_in(row_in));
  //////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, ex);
    cmp_count++;
    if (seen !== ex)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // one apb transfer; the note goes in the queue first
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, cr, ex,
    input logic er);
    int n = 0;
    q.push_back('{er, cr, ex & cr});
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do
      @(posedge pclk);
    while (pready !== 1'b1 && ++n < 50);
    if (n == 50)
      n_mismatch++;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d, 0, 0, 0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] cr, ex);
    apb(0, a, 0, cr, ex, 0);
  endtask
  // bounded wait on irq (s=1) or clk_req (s=0)
  task automatic wt(input bit s, input logic v);
    int n = 0;
    while ((s ? irq : clk_req) !== v && n++ < 40000)
      @(posedge pclk);
    check(s ? "irq" : "clk_req", s ? irq : clk_req, v);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // answer monitor: the oldest note meets each completed transfer
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1)
    begin
      check("pslverr", pslverr, q[0].err);
      if (!pwrite)
        check("prdata", prdata & q[0].care, q[0].val);
      void'(q.pop_front());
    end
  initial
  begin
    #700000;
    n_mismatch++;
    end_of_test;
  end
  //////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(KMS_CTRL_OFS, '1, KMS_CTRL_RST);
    rd(KMS_MASK_OFS, '1, 0);
    rd(KMS_KEY_OFS, 32'h0000_00ff, 32'h0000_00ff);
    rd(KMS_LVL_OFS, '1, 0);
    rnd = xs(rnd);
    apb(1, 8'h44, rnd, 0, 0, 1);
    wt(0, 0);
    // field limits clamp at 1 and at 8 rows / 20 columns
    wr(KMS_CTRL_OFS, 32'h0000_1ff1);
    rd(KMS_CTRL_OFS, 32'h0000_1ff1, 32'h0000_1481);
    wr(KMS_CTRL_OFS, 32'h0000_0001);
    rd(KMS_CTRL_OFS, 32'h0000_1ff1, 32'h0000_0111);
    wr(KMS_CTRL_OFS, 32'h0000_0221);
    $display("test reset and config done");
    wr(KMS_MASK_OFS, 32'h0000_0001);
    rnd = xs(rnd);
    r = rnd[0];
    c = rnd[1];
    keys[c*8+r] <= 1'b1;
    wt(0, 1);
    wt(1, 1);
    rd(KMS_LVL_OFS, '1, 1);
    rd(KMS_KEY_OFS, 32'h0000_00ff, r + c * 2);
    rd(KMS_KEY_OFS, 32'h0000_00ff, 32'h0000_00ff);
    keys <= '0;
    wt(0, 0);
    wr(KMS_MASK_OFS, 0);
    wt(1, 0);
    wr(KMS_MASK_OFS, 32'h0000_0001);
    wt(1, 1);
    wr(KMS_STAT_OFS, 32'h0000_0001);
    wt(1, 0);
    $display("test single key done");
    // a press far shorter than one scan step must leave nothing behind
    keys[0] <= 1'b1;
    repeat (100) @(posedge pclk);
    keys[0] <= 1'b0;
    wt(0, 1);
    wt(0, 0);
    rd(KMS_LVL_OFS, '1, 0);
    $display("test glitch done");
    wr(KMS_MASK_OFS, 32'h0000_0002);
    keys <= 160'h0103;
    wt(1, 1);
    rd(KMS_STAT_OFS, 32'h0000_0006, 32'h0000_0002);
    keys <= '0;
    wt(0, 0);
    wr(KMS_STAT_OFS, 32'h0000_0007);
    wt(1, 0);
    rd(KMS_STAT_OFS, 32'h0000_0007, 0);
    $display("test ghost done");
    // one key on a 1 by 1 matrix pushes once per pass until the buffer fills
    wr(KMS_CTRL_OFS, 32'h0000_0111);
    wr(KMS_MASK_OFS, 32'h0000_0004);
    keys[0] <= 1'b1;
    wt(1, 1);
    rd(KMS_LVL_OFS, '1, 16);
    rd(KMS_STAT_OFS, 32'h0000_0004, 32'h0000_0004);
    keys <= '0;
    wt(0, 0);
    rd(KMS_LVL_OFS, '1, 16);
    $display("test overflow done");
    end_of_test;
  end
endmodule
